/* File: hdl/tqec_core.sv */
// Sixteen-bit up/down counter with reload register.
// Assumes one-cycle event pulses and a one-cycle timer write strobe.
module tqec_core
    import tqec_pkg::*;
#(
    parameter int W = TQEC_CNT_W
)(
    input  wire logic         mclk,
    input  wire logic         rstn,
    tqec_evt_if.dst           evt,
    input  wire logic         start,
    input  wire logic         free_run,
    input  wire logic         wr_stb,
    input  wire logic [W-1:0] wr_data,
    output logic      [W-1:0] count,
    output logic              ovf,
    output logic              udf
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic [W-1:0] reload;
        logic         ovf;
        logic         udf;
    } tqec_core_s;

    tqec_core_s st_r;
    tqec_core_s st_nxt;

    always_comb begin
        st_nxt     = st_r;
        st_nxt.ovf = 1'b0;
        st_nxt.udf = 1'b0;
        if (wr_stb) begin
            st_nxt.reload = wr_data;
        end
        if (start && evt.up) begin
            if (st_r.cnt == '1) begin
                st_nxt.ovf = 1'b1;
                // Overflowing past all ones from n takes FFFF-n+1 events.
                st_nxt.cnt = free_run ? '0 : st_r.reload;
            end else begin
                st_nxt.cnt = W'(st_r.cnt + 1'b1);
            end
        end else if (start && evt.down) begin
            if (st_r.cnt == '0) begin
                st_nxt.udf = 1'b1;
                st_nxt.cnt = free_run ? '1 : st_r.reload;
            end else begin
                st_nxt.cnt = W'(st_r.cnt - 1'b1);
            end
        end
        if (wr_stb && !start) begin
            st_nxt.cnt = wr_data;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_r <= {TQEC_CNT_RST, TQEC_RELOAD_RST, 1'b0, 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign count = st_r.cnt;
    assign ovf   = st_r.ovf;
    assign udf   = st_r.udf;

    property p_ovf_reload;
        @(posedge mclk) disable iff (!rstn)
        start && evt.up && st_r.cnt == '1 && !free_run && !wr_stb |=> ovf && count == $past(st_r.reload);
    endproperty
    a_ovf_reload: assert property (p_ovf_reload) else $error("overflow did not reload");

    property p_udf_reload;
        @(posedge mclk) disable iff (!rstn)
        start && evt.down && st_r.cnt == '0 && !free_run && !wr_stb |=> udf && count == $past(st_r.reload);
    endproperty
    a_udf_reload: assert property (p_udf_reload) else $error("underflow did not reload");

    property p_stop_hold;
        @(posedge mclk) disable iff (!rstn)
        !start && !wr_stb |=> $stable(count) && !ovf && !udf;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("counter moved while stopped");

    property p_up_step;
        @(posedge mclk) disable iff (!rstn)
        start && evt.up && st_r.cnt != '1 |=> count == W'($past(st_r.cnt) + 1'b1);
    endproperty
    a_up_step: assert property (p_up_step) else $error("up event did not increment");

    property p_stop_write;
        @(posedge mclk) disable iff (!rstn)
        wr_stb && !start |=> count == $past(wr_data) && st_r.reload == $past(wr_data);
    endproperty
    a_stop_write: assert property (p_stop_write) else $error("stopped write missed counter");

    property p_run_write;
        @(posedge mclk) disable iff (!rstn)
        wr_stb && start && !evt.up && !evt.down |=> $stable(count) && st_r.reload == $past(wr_data);
    endproperty
    a_run_write: assert property (p_run_write) else $error("running write touched counter");
endmodule

/* File: hdl/tqec_decode.sv */
// Two-phase pin decoder producing up and down count pulses.
// Assumes both pins are already synchronous to mclk.
module tqec_decode
    import tqec_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic phase_a_pin,
    input  wire logic phase_b_pin,
    input  wire logic x4_mode,
    tqec_evt_if.src   evt
);
    typedef struct packed {
        logic a_q;
        logic b_q;
        logic up;
        logic down;
    } tqec_dec_s;

    tqec_dec_s st_r;
    tqec_dec_s st_nxt;
    logic      a_rise;
    logic      a_fall;
    logic      b_rise;
    logic      b_fall;
    logic      one_chg;

    always_comb begin
        a_rise  = phase_a_pin & ~st_r.a_q;
        a_fall  = ~phase_a_pin & st_r.a_q;
        b_rise  = phase_b_pin & ~st_r.b_q;
        b_fall  = ~phase_b_pin & st_r.b_q;
        // Both pins moving at once carry no direction, so such a step is dropped.
        one_chg = (a_rise | a_fall) ^ (b_rise | b_fall);
        st_nxt     = st_r;
        st_nxt.a_q = phase_a_pin;
        st_nxt.b_q = phase_b_pin;
        if (x4_mode) begin
            st_nxt.up   = one_chg & ((a_rise & phase_b_pin) | (a_fall & ~phase_b_pin)
                        | (b_rise & ~phase_a_pin) | (b_fall & phase_a_pin));
            st_nxt.down = one_chg & ((a_rise & ~phase_b_pin) | (a_fall & phase_b_pin)
                        | (b_rise & phase_a_pin) | (b_fall & ~phase_a_pin));
        end else begin
            st_nxt.up   = a_rise & phase_b_pin & st_r.b_q;
            st_nxt.down = a_fall & phase_b_pin & st_r.b_q;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign evt.up   = st_r.up;
    assign evt.down = st_r.down;

    sequence s_a_rise_b_high;
        !st_r.a_q && phase_a_pin && st_r.b_q && phase_b_pin;
    endsequence

    property p_norm_up;
        @(posedge mclk) disable iff (!rstn)
        (!x4_mode) and s_a_rise_b_high |=> evt.up && !evt.down;
    endproperty
    a_norm_up: assert property (p_norm_up) else $error("normal rise did not count up");

    property p_x4_b_rise;
        @(posedge mclk) disable iff (!rstn)
        x4_mode && !st_r.b_q && phase_b_pin && !st_r.a_q && !phase_a_pin |=> evt.up && !evt.down;
    endproperty
    a_x4_b_rise: assert property (p_x4_b_rise) else $error("x4 edge did not count up");
endmodule

/* File: hdl/tqec_evt_if.sv */
// Count events passed from the pin decoder to the counter core.
// Assumes both ends run on mclk; up and down are one-cycle pulses.
interface tqec_evt_if;
    logic up;
    logic down;
    modport src (output up, output down);
    modport dst (input up, input down);
endinterface

/* File: hdl/tqec_pkg.sv */
// Constants of the two-phase quadrature event counter.
// Assumes one 100 MHz clock and a 32-bit AXI4-Lite register bus.
package tqec_pkg;
    localparam int          TQEC_CNT_W      = 16;
    localparam int          TQEC_ADDR_W     = 8;
    localparam logic [7:0]  TQEC_OFS_CTRL   = 8'h00;
    localparam logic [7:0]  TQEC_OFS_TIMER  = 8'h04;
    localparam logic [7:0]  TQEC_OFS_STAT   = 8'h08;
    localparam logic [7:0]  TQEC_OFS_MASK   = 8'h0c;
    localparam int          TQEC_CTRL_START = 0;
    localparam int          TQEC_CTRL_FREE  = 1;
    localparam int          TQEC_CTRL_X4    = 2;
    localparam int          TQEC_STAT_OVF   = 0;
    localparam int          TQEC_STAT_UDF   = 1;
    localparam logic [15:0] TQEC_CNT_RST    = 16'h0000;
    localparam logic [15:0] TQEC_RELOAD_RST = 16'h0000;
    localparam logic [1:0]  TQEC_STAT_RST   = 2'h0;
    localparam logic [1:0]  TQEC_MASK_RST   = 2'h0;
    localparam logic [1:0]  TQEC_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  TQEC_RESP_SLV   = 2'h2;
    typedef enum logic [3:0] {
        TQEC_REG_CTRL  = 4'h1,
        TQEC_REG_TIMER = 4'h2,
        TQEC_REG_STAT  = 4'h4,
        TQEC_REG_MASK  = 4'h8
    } tqec_reg_e;
endpackage

/* File: hdl/tqec_top.sv */
// Quadrature event counter with AXI4-Lite registers and a level interrupt.
// Assumes the pins are synchronous to mclk and one bus master.
//
// Contract
// - Count events come from the two phase pins, both used as inputs.
// - Direction follows the phase relation of the pins, with no software select.
// - Overflow or underflow reloads the counter, unless free-run is selected.
// - Division ratio is 1/(FFFF-n+1) counting up and 1/(n+1) counting down.
// - Counting runs while the start flag is 1 and halts when it is 0.
// - An overflow or underflow raises the interrupt request when its mask bit is set.
// - Reading the timer register returns the present count.
// - A write while stopped loads both reload register and counter.
// - A write while running loads only the reload register.
// - Normal mode counts phase A rises up, falls down, while phase B is high.
// - Multiply-by-4 counts every single-pin edge of both pins, direction from phase order.
// - Only timer 3 selects the mode; timer 2 is normal, timer 4 multiply-by-4.
module tqec_top
    import tqec_pkg::*;
#(
    parameter int TIMER_SEL = 3
)(
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    input  wire logic                   phase_a_pin,
    input  wire logic                   phase_b_pin,
    input  wire logic [TQEC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [TQEC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic                        irq
);
    typedef struct packed {
        logic                   awready;
        logic                   wready;
        logic                   arready;
        logic                   aw_got;
        logic                   w_got;
        logic [TQEC_ADDR_W-1:0] awaddr;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic                   start;
        logic                   free_run;
        logic                   x4_sel;
        logic [1:0]             status;
        logic [1:0]             mask;
        logic                   tw_stb;
        logic [15:0]            tw_data;
        logic                   irq;
    } tqec_top_s;

    tqec_top_s       st_r;
    tqec_top_s       st_nxt;
    logic            x4_eff;
    logic [15:0]     count;
    logic            cnt_ovf;
    logic            cnt_udf;
    logic [1:0]      stat_set;
    logic [1:0]      stat_clr;
    logic [31:0]     wr_val;
    logic [3:0]      wr_hit;
    logic [3:0]      rd_hit;
    logic            rd_take;

    tqec_evt_if evt ();

    function automatic logic [3:0] tqec_decode_addr(input logic [TQEC_ADDR_W-1:0] addr);
        logic [3:0] hit;
        hit = 4'h0;
        unique case (addr)
            TQEC_OFS_CTRL:  hit = TQEC_REG_CTRL;
            TQEC_OFS_TIMER: hit = TQEC_REG_TIMER;
            TQEC_OFS_STAT:  hit = TQEC_REG_STAT;
            TQEC_OFS_MASK:  hit = TQEC_REG_MASK;
            default:        hit = 4'h0;
        endcase
        return hit;
    endfunction

    function automatic logic [31:0] tqec_merge(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Timer 3 alone lets software pick the mode; the others are hardwired.
    assign x4_eff = (TIMER_SEL == 4) || ((TIMER_SEL == 3) && st_r.x4_sel);

    tqec_decode u_decode (
        .mclk        (mclk),
        .rstn        (rstn),
        .phase_a_pin (phase_a_pin),
        .phase_b_pin (phase_b_pin),
        .x4_mode     (x4_eff),
        .evt         (evt.src)
    );

    tqec_core #(
        .W (TQEC_CNT_W)
    ) u_core (
        .mclk     (mclk),
        .rstn     (rstn),
        .evt      (evt.dst),
        .start    (st_r.start),
        .free_run (st_r.free_run),
        .wr_stb   (st_r.tw_stb),
        .wr_data  (st_r.tw_data),
        .count    (count),
        .ovf      (cnt_ovf),
        .udf      (cnt_udf)
    );

    always_comb begin
        st_nxt        = st_r;
        st_nxt.tw_stb = 1'b0;
        wr_hit        = tqec_decode_addr(st_r.awaddr);
        rd_hit        = tqec_decode_addr(s_axi_araddr);
        rd_take       = s_axi_arvalid && st_r.arready;
        wr_val        = 32'h0;
        stat_clr      = 2'h0;
        stat_set      = {cnt_udf, cnt_ovf};

        // Address and data may arrive in either order; each is held until both are in.
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.aw_got && st_r.w_got) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = (wr_hit == 4'h0) ? TQEC_RESP_SLV : TQEC_RESP_OKAY;
            unique case (wr_hit)
                TQEC_REG_CTRL: begin
                    wr_val = tqec_merge({29'h0, st_r.x4_sel, st_r.free_run, st_r.start},
                                        st_r.wdata, st_r.wstrb);
                    st_nxt.start    = wr_val[TQEC_CTRL_START];
                    st_nxt.free_run = wr_val[TQEC_CTRL_FREE];
                    st_nxt.x4_sel   = (TIMER_SEL == 3) && wr_val[TQEC_CTRL_X4];
                end
                TQEC_REG_TIMER: begin
                    wr_val = tqec_merge({16'h0, count}, st_r.wdata, st_r.wstrb);
                    // The core decides reload-only or both from the start flag.
                    st_nxt.tw_stb  = 1'b1;
                    st_nxt.tw_data = wr_val[15:0];
                end
                TQEC_REG_MASK: begin
                    wr_val      = tqec_merge({30'h0, st_r.mask}, st_r.wdata, st_r.wstrb);
                    st_nxt.mask = wr_val[1:0];
                end
                default: begin
                    wr_val = 32'h0;
                end
            endcase
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        if (rd_take) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = (rd_hit == 4'h0) ? TQEC_RESP_SLV : TQEC_RESP_OKAY;
            unique case (rd_hit)
                TQEC_REG_CTRL:  st_nxt.rdata = {29'h0, x4_eff, st_r.free_run, st_r.start};
                TQEC_REG_TIMER: st_nxt.rdata = {16'h0, count};
                TQEC_REG_STAT: begin
                    st_nxt.rdata = {30'h0, st_r.status};
                    stat_clr     = st_r.status;
                end
                TQEC_REG_MASK:  st_nxt.rdata = {30'h0, st_r.mask};
                default:        st_nxt.rdata = 32'h0;
            endcase
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end

        // A new event in the clearing cycle survives: the set is applied last.
        st_nxt.status  = (st_r.status & ~stat_clr) | stat_set;
        st_nxt.irq     = |(st_nxt.status & st_nxt.mask);
        st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
        st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;
        st_nxt.arready = !st_nxt.rvalid;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_r        <= '0;
            st_r.status <= TQEC_STAT_RST;
            st_r.mask   <= TQEC_MASK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready  = st_r.wready;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;
    assign irq           = st_r.irq;

    sequence s_timer_read;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == TQEC_OFS_TIMER;
    endsequence

    property p_read_count;
        @(posedge mclk) disable iff (!rstn)
        s_timer_read |=> s_axi_rvalid && s_axi_rdata == {16'h0, $past(count)};
    endproperty
    a_read_count: assert property (p_read_count) else $error("timer read lost the count");

    // Outputs are registered, so each implication check looks one edge after its cause.
    sequence s_stat_read;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == TQEC_OFS_STAT;
    endsequence

    // Set beats the read clear, so an event in the clearing cycle is kept.
    property p_stat_clear;
        @(posedge mclk) disable iff (!rstn)
        s_stat_read |=> st_r.status == $past(stat_set);
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("status read did not clear");

    property p_irq_udf;
        @(posedge mclk) disable iff (!rstn)
        cnt_udf && st_r.mask[TQEC_STAT_UDF] |=> irq && st_r.status[TQEC_STAT_UDF];
    endproperty
    a_irq_udf: assert property (p_irq_udf) else $error("underflow raised no interrupt");

    // The output flop shares its next state with the flags, so it never lags them.
    property p_irq_level;
        @(posedge mclk) disable iff (!rstn)
        irq == |(st_r.status & st_r.mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    sequence s_timer_commit;
        st_r.aw_got && st_r.w_got && wr_hit == TQEC_REG_TIMER;
    endsequence

    property p_timer_strobe;
        @(posedge mclk) disable iff (!rstn)
        s_timer_commit |=> st_r.tw_stb && s_axi_bvalid && s_axi_bresp == TQEC_RESP_OKAY;
    endproperty
    a_timer_strobe: assert property (p_timer_strobe) else $error("timer write gave no strobe");

    property p_start_write;
        @(posedge mclk) disable iff (!rstn)
        st_r.aw_got && st_r.w_got && wr_hit == TQEC_REG_CTRL && st_r.wstrb[0]
            |=> st_r.start == $past(st_r.wdata[TQEC_CTRL_START]);
    endproperty
    a_start_write: assert property (p_start_write) else $error("start flag not written");

    sequence s_ctrl_read;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == TQEC_OFS_CTRL;
    endsequence

    property p_ctrl_read;
        @(posedge mclk) disable iff (!rstn)
        s_ctrl_read |=> s_axi_rdata[TQEC_CTRL_X4]
            == ((TIMER_SEL == 4) || ((TIMER_SEL == 3) && $past(st_r.x4_sel)));
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("mode read back wrong");

    property p_irq_ovf;
        @(posedge mclk) disable iff (!rstn)
        cnt_ovf && st_r.mask[TQEC_STAT_OVF] |=> irq && st_r.status[TQEC_STAT_OVF];
    endproperty
    a_irq_ovf: assert property (p_irq_ovf) else $error("overflow raised no interrupt");

    // Timers 2 and 4 must never latch a mode bit that software wrote.
    property p_mode_sel;
        @(posedge mclk) disable iff (!rstn)
        (x4_eff == ((TIMER_SEL == 4) || st_r.x4_sel))
            && ((TIMER_SEL == 3) || !st_r.x4_sel);
    endproperty
    a_mode_sel: assert property (p_mode_sel) else $error("mode select wrong for timer");
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the quadrature event counter.
// Assumes the encoder model drives the pins and the bench is the only bus master.
module tb_top
    import tqec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        step_req = 1'b0;
    logic        step_dir = 1'b0;
    logic        pa, pb, irq;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [33:0] exp_q[$];
    int          fail_count = 0;
    int          checks = 0;
    logic [15:0] n, m;
    int          k;

    initial begin
        forever #5 mclk = ~mclk;
    end

    tqec_enc_model i_tqec_enc_model (.mclk(mclk), .rstn(rstn), .step_req(step_req), .step_dir(step_dir),
                                     .phase_a_pin(pa), .phase_b_pin(pb));
    tqec_top i_tqec_top (.mclk(mclk), .rstn(rstn), .phase_a_pin(pa), .phase_b_pin(pb),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq));

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Write: both channels offered together, each released when taken.
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        logic aw_done, w_done;
        exp_q.push_back({er, 32'h0});
        @(posedge mclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {16'h0, d};
        wstrb   <= 4'hf;
        wvalid  <= 1'b1;
        aw_done = 1'b0;
        w_done  = 1'b0;
        while (!(aw_done && w_done)) begin
            @(posedge mclk);
            if (awvalid && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge mclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        exp_q.push_back({er, 16'h0, d});
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do @(posedge mclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask

    // Steps with random gaps, so the encoder is sometimes prompt and sometimes slow.
    task automatic step(input logic dir, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            @(posedge mclk);
            step_req <= 1'b1;
            step_dir <= dir;
            @(posedge mclk);
            step_req <= 1'b0;
            repeat ($urandom % 3) @(posedge mclk);
        end
        repeat (5) @(posedge mclk);
    endtask

    // Responses are compared against the oldest note, in issue order.
    always @(posedge mclk) begin
        if (rvalid && rready) begin
            chk({rresp, rdata}, exp_q.pop_front());
        end
        if (bvalid && bready) begin
            chk({bresp, 32'h0}, exp_q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        wrap_up();
    end

    initial begin
        k = $urandom(99604);
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rd(TQEC_OFS_CTRL, 16'h0, TQEC_RESP_OKAY);
        rd(TQEC_OFS_TIMER, TQEC_CNT_RST, TQEC_RESP_OKAY);
        rd(TQEC_OFS_STAT, 16'h0, TQEC_RESP_OKAY);
        rd(TQEC_OFS_MASK, 16'h0, TQEC_RESP_OKAY);
        rd(8'h10, 16'h0, TQEC_RESP_SLV);
        wr(8'h10, 16'h5a5a, TQEC_RESP_SLV);
        wr(TQEC_OFS_STAT, 16'h3, TQEC_RESP_OKAY);
        rd(TQEC_OFS_STAT, 16'h0, TQEC_RESP_OKAY);
        n = 16'h0100 + 16'($urandom % 32'hfe00);
        wr(TQEC_OFS_TIMER, n, TQEC_RESP_OKAY);
        rd(TQEC_OFS_TIMER, n, TQEC_RESP_OKAY);
        step(1'b1, 4);
        rd(TQEC_OFS_TIMER, n, TQEC_RESP_OKAY);
        wr(TQEC_OFS_CTRL, 16'h1, TQEC_RESP_OKAY);
        k = 1 + $urandom % 3;
        step(1'b1, 4 * k);
        rd(TQEC_OFS_TIMER, n + 16'(k), TQEC_RESP_OKAY);
        step(1'b0, 8);
        rd(TQEC_OFS_TIMER, n + 16'(k) - 16'h2, TQEC_RESP_OKAY);
        wr(TQEC_OFS_CTRL, 16'h5, TQEC_RESP_OKAY);
        rd(TQEC_OFS_CTRL, 16'h5, TQEC_RESP_OKAY);
        step(1'b1, 3);
        rd(TQEC_OFS_TIMER, n + 16'(k) + 16'h1, TQEC_RESP_OKAY);
        step(1'b0, 5);
        rd(TQEC_OFS_TIMER, n + 16'(k) - 16'h4, TQEC_RESP_OKAY);
        wr(TQEC_OFS_CTRL, 16'h4, TQEC_RESP_OKAY);
        wr(TQEC_OFS_TIMER, 16'hfffd, TQEC_RESP_OKAY);
        wr(TQEC_OFS_MASK, 16'h1, TQEC_RESP_OKAY);
        wr(TQEC_OFS_CTRL, 16'h5, TQEC_RESP_OKAY);
        step(1'b1, 2);
        rd(TQEC_OFS_TIMER, 16'hffff, TQEC_RESP_OKAY);
        chk({33'h0, irq}, 34'h0);
        step(1'b1, 1);
        chk({33'h0, irq}, 34'h1);
        rd(TQEC_OFS_TIMER, 16'hfffd, TQEC_RESP_OKAY);
        rd(TQEC_OFS_STAT, 16'h1, TQEC_RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk({33'h0, irq}, 34'h0);
        rd(TQEC_OFS_STAT, 16'h0, TQEC_RESP_OKAY);
        wr(TQEC_OFS_CTRL, 16'h4, TQEC_RESP_OKAY);
        wr(TQEC_OFS_TIMER, 16'h2, TQEC_RESP_OKAY);
        wr(TQEC_OFS_CTRL, 16'h5, TQEC_RESP_OKAY);
        step(1'b0, 2);
        rd(TQEC_OFS_TIMER, 16'h0, TQEC_RESP_OKAY);
        step(1'b0, 1);
        chk({33'h0, irq}, 34'h0);
        rd(TQEC_OFS_TIMER, 16'h2, TQEC_RESP_OKAY);
        rd(TQEC_OFS_STAT, 16'h2, TQEC_RESP_OKAY);
        wr(TQEC_OFS_CTRL, 16'h4, TQEC_RESP_OKAY);
        wr(TQEC_OFS_TIMER, 16'hffff, TQEC_RESP_OKAY);
        wr(TQEC_OFS_CTRL, 16'h5, TQEC_RESP_OKAY);
        m = 16'($urandom);
        wr(TQEC_OFS_TIMER, m, TQEC_RESP_OKAY);
        rd(TQEC_OFS_TIMER, 16'hffff, TQEC_RESP_OKAY);
        step(1'b1, 1);
        rd(TQEC_OFS_TIMER, m, TQEC_RESP_OKAY);
        rd(TQEC_OFS_STAT, 16'h1, TQEC_RESP_OKAY);
        wr(TQEC_OFS_CTRL, 16'h4, TQEC_RESP_OKAY);
        wr(TQEC_OFS_TIMER, 16'hffff, TQEC_RESP_OKAY);
        wr(TQEC_OFS_CTRL, 16'h7, TQEC_RESP_OKAY);
        step(1'b1, 1);
        rd(TQEC_OFS_TIMER, 16'h0, TQEC_RESP_OKAY);
        wr(TQEC_OFS_TIMER, 16'h1234, TQEC_RESP_OKAY);
        step(1'b0, 1);
        rd(TQEC_OFS_TIMER, 16'hffff, TQEC_RESP_OKAY);
        rd(TQEC_OFS_STAT, 16'h3, TQEC_RESP_OKAY);
        wrap_up();
    end
endmodule

/* File: verif/tqec_enc_model.sv */
// Two-phase pulse source that stands in for a quadrature encoder.
// Assumes the bench pulses step_req for one mclk cycle for each step.
module tqec_enc_model (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic step_req,
    input  wire logic step_dir,
    output logic      phase_a_pin,
    output logic      phase_b_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pos_r;
    // Gray order changes one pin per step, so no step is ever ambiguous.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pos_r <= 2'h0;
        end else if (step_req) begin
            pos_r <= step_dir ? pos_r + 2'h1 : pos_r - 2'h1;
        end
    end
    // Both pins are driven only by this source and read by the block.
    assign phase_a_pin = pos_r[1];
    assign phase_b_pin = pos_r[1] ^ pos_r[0];
endmodule
